// file: shared/rcr_map.svh
// Behaviour
// - timer pointer bits 9:8 select value pair
// - timer map min/sec, wday/hr, mon/day, year
// - timer high write decrements pointer, stops 00
// - alarm pointer bits 9:8 select alarm pair
// - alarm map min/sec, wday/hr, mon/day, none
// - alarm high write decrements pointer, stops 00
// - any window byte read decrements pointer
// - timekeeping writes ignored unless unlock set
// - unlock set only right after 55h, AAh
// - positive code adds four pulses per step
// - negative code removes four pulses per step
// - zero code leaves pulse count unchanged
// - config register cleared by power-on only; alarm config register cleared by reset or power-on
// - run enable written only while unlocked
// - minute/second low write clears status bit
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH
// ************************************************************
// register word addresses (byte address = index * 4)
// ************************************************************
`define RCR_ADR_CFG      4'h0
`define RCR_ADR_TVAL     4'h1
`define RCR_ADR_ACFG     4'h2
`define RCR_ADR_AVAL     4'h3
`define RCR_ADR_KEY      4'h4
`define RCR_ADR_PULSE    4'h5
// ************************************************************
// fields
// ************************************************************
`define RCR_PTR_HI       9
`define RCR_PTR_LO       8
`define RCR_BIT_RUN      15
`define RCR_BIT_UNLOCK   13
`define RCR_BIT_STAT     12
`define RCR_CAL_HI       7
`define RCR_KEY1         8'h55
`define RCR_KEY2         8'haa
`define RCR_KEY_WIN      2'h2
`define RCR_CFG_RST      16'h0000
`define RCR_CAL_STEP_SH  2
`endif

// file: shared/rcr_pkg.sv
package rcr_pkg;
    typedef enum logic [1:0] {
        RCR_KEY_IDLE,
        RCR_KEY_GOT1,
        RCR_KEY_OPEN
    } rcr_key_t;
    typedef logic [7:0] rcr_byte_t;
endpackage

// file: shared/rcr_win_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rcr_win_if;
    logic [1:0] ptr_nxt_view;
    logic       rd;
    logic       wr_hi;
    logic       load;
    logic [1:0] load_val;
    logic [1:0] ptr_q;
    modport ctrl (output ptr_q, output ptr_nxt_view,
                  input rd, input wr_hi, input load, input load_val);
    modport user (input ptr_q, input ptr_nxt_view,
                  output rd, output wr_hi, output load, output load_val);
endinterface
`default_nettype wire

// file: core/rcr_win_ptr.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcr_map.svh"
// window pointer with auto-decrement floored at zero
module rcr_win_ptr (
    // system
    input  wire logic    clk_i,
    input  wire logic    por_i,
    // window
    rcr_win_if.ctrl      win
);
    logic [1:0] ptr_r;
    logic [1:0] ptr_nxt;
    always_comb begin
        ptr_nxt = ptr_r;
        if (win.load) begin
            ptr_nxt = win.load_val;
        end else if ((win.rd || win.wr_hi) && ptr_r != 2'h0) begin
            ptr_nxt = ptr_r - 2'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            ptr_r <= 2'h0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end
    assign win.ptr_q = ptr_r;
    // next value lets the owner mirror the field without a one-cycle lag
    assign win.ptr_nxt_view = ptr_nxt;
    AST_PTR_FLOOR: assert property (@(posedge clk_i) disable iff (por_i)
        (!win.load && (win.rd || win.wr_hi) && ptr_r == 2'h0) |=> ptr_r == 2'h0)
        else $error("pointer left zero on access");
    AST_PTR_DEC: assert property (@(posedge clk_i) disable iff (por_i)
        (!win.load && win.rd && ptr_r != 2'h0) |=> ptr_r == $past(ptr_r) - 2'h1)
        else $error("pointer did not decrement on read");
endmodule
`default_nettype wire

// file: core/rcr_cal.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcr_map.svh"
// once-a-minute drift trim: signed code times four pulses
module rcr_cal (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // trim
    input  wire logic        minute_i,
    input  wire logic [7:0]  code_i,
    output logic             add_o,
    output logic             drop_o,
    output logic [9:0]       pulses_o
);
    logic [9:0] mag_r;
    logic [9:0] mag_nxt;
    logic       add_r;
    logic       add_nxt;
    logic       drop_r;
    logic       drop_nxt;
    logic [9:0] abs_code;
    always_comb begin
        abs_code = code_i[`RCR_CAL_HI] ? {2'h0, 8'(-code_i)} : {2'h0, code_i};
        mag_nxt  = mag_r;
        add_nxt  = 1'b0;
        drop_nxt = 1'b0;
        if (minute_i) begin
            mag_nxt  = abs_code << `RCR_CAL_STEP_SH;
            add_nxt  = !code_i[`RCR_CAL_HI] && code_i != 8'h00;
            drop_nxt = code_i[`RCR_CAL_HI];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mag_r  <= 10'h000;
            add_r  <= 1'b0;
            drop_r <= 1'b0;
        end else begin
            mag_r  <= mag_nxt;
            add_r  <= add_nxt;
            drop_r <= drop_nxt;
        end
    end
    assign add_o    = add_r;
    assign drop_o   = drop_r;
    assign pulses_o = mag_r;
    AST_CAL_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (minute_i && code_i == 8'h00) |=> !add_r && !drop_r)
        else $error("zero code changed pulse count");
    AST_CAL_MAX_NEG: assert property (@(posedge clk_i) disable iff (rst_i)
        (minute_i && code_i == 8'h80) |=> drop_r && mag_r == 10'h200)
        else $error("code 80h did not drop 512 pulses");
    AST_CAL_MAX_POS: assert property (@(posedge clk_i) disable iff (rst_i)
        (minute_i && code_i == 8'h7f) |=> add_r && mag_r == 10'h1fc)
        else $error("code 7fh did not add 508 pulses");
endmodule
`default_nettype wire

// file: core/rcr_core.sv
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_map.svh"
module rcr_core (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // time base
    input  wire logic        minute_i,
    output logic             run_o,
    output logic             cal_add_o,
    output logic             cal_drop_o,
    output logic [9:0]       cal_pulses_o,
    output logic             tk_wr_o
);
    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [15:0] acfg_r;
    logic [15:0] acfg_nxt;
    logic [7:0]  tk_r [0:7];
    logic [7:0]  al_r [0:5];
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        tkw_r;
    logic        tkw_nxt;
    rcr_pkg::rcr_key_t key_r;
    rcr_pkg::rcr_key_t key_nxt;
    logic [1:0]  keyage_r;
    logic [1:0]  keyage_nxt;
    rcr_win_if tw ();
    rcr_win_if aw ();
    // ************************************************************
    // bus decode
    // ************************************************************
    logic       req;
    logic       wr;
    logic       rd;
    logic [3:0] idx;
    logic [2:0] t_lo;
    logic [2:0] t_hi;
    logic [2:0] a_lo;
    logic [2:0] a_hi;
    logic       unlock;
    assign req    = cyc_i && stb_i && !ack_r;
    assign wr     = req && we_i;
    assign rd     = req && !we_i;
    assign idx    = adr_i[5:2];
    assign unlock = cfg_r[`RCR_BIT_UNLOCK];
    // pair slots: ptr*2 low, ptr*2+1 high
    assign t_lo   = {tw.ptr_q, 1'b0};
    assign t_hi   = {tw.ptr_q, 1'b1};
    assign a_lo   = {aw.ptr_q, 1'b0};
    assign a_hi   = {aw.ptr_q, 1'b1};
    assign tw.rd       = rd && idx == `RCR_ADR_TVAL && |sel_i[1:0];
    assign tw.wr_hi    = wr && idx == `RCR_ADR_TVAL && sel_i[1] && unlock;
    assign tw.load     = wr && idx == `RCR_ADR_CFG && sel_i[1];
    assign tw.load_val = dat_i[`RCR_PTR_HI:`RCR_PTR_LO];
    assign aw.rd       = rd && idx == `RCR_ADR_AVAL && |sel_i[1:0];
    assign aw.wr_hi    = wr && idx == `RCR_ADR_AVAL && sel_i[1];
    assign aw.load     = wr && idx == `RCR_ADR_ACFG && sel_i[1];
    assign aw.load_val = dat_i[`RCR_PTR_HI:`RCR_PTR_LO];
    rcr_win_ptr u_tptr (
        .clk_i (clk_i),
        .por_i (por_i),
        .win   (tw.ctrl)
    );
    rcr_win_ptr u_aptr (
        .clk_i (clk_i),
        .por_i (por_i),
        .win   (aw.ctrl)
    );
    // ************************************************************
    // unlock key sequencer
    // ************************************************************
    logic key_wr;
    assign key_wr = wr && idx == `RCR_ADR_KEY && sel_i[0];
    always_comb begin
        key_nxt    = key_r;
        keyage_nxt = keyage_r;
        case (key_r)
            rcr_pkg::RCR_KEY_IDLE: begin
                if (key_wr && dat_i[7:0] == `RCR_KEY1) begin
                    key_nxt = rcr_pkg::RCR_KEY_GOT1;
                end
            end
            rcr_pkg::RCR_KEY_GOT1: begin
                if (key_wr) begin
                    key_nxt    = (dat_i[7:0] == `RCR_KEY2) ? rcr_pkg::RCR_KEY_OPEN
                                                           : rcr_pkg::RCR_KEY_IDLE;
                    keyage_nxt = 2'h0;
                end else if (req) begin
                    key_nxt = rcr_pkg::RCR_KEY_IDLE;
                end
            end
            rcr_pkg::RCR_KEY_OPEN: begin
                // window closes after one more bus access or a few idle cycles
                keyage_nxt = keyage_r + 2'h1;
                if (req || keyage_r == `RCR_KEY_WIN) begin
                    key_nxt = rcr_pkg::RCR_KEY_IDLE;
                end
            end
            default: key_nxt = rcr_pkg::RCR_KEY_IDLE;
        endcase
    end
    // ************************************************************
    // configuration registers and value writes
    // ************************************************************
    always_comb begin
        cfg_nxt  = cfg_r;
        acfg_nxt = acfg_r;
        tkw_nxt  = 1'b0;
        if (wr && idx == `RCR_ADR_CFG) begin
            if (sel_i[0]) begin
                cfg_nxt[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
                cfg_nxt[`RCR_PTR_HI:`RCR_PTR_LO] = dat_i[`RCR_PTR_HI:`RCR_PTR_LO];
                // clearing always allowed; setting needs an open key window
                if (!dat_i[`RCR_BIT_UNLOCK]) begin
                    cfg_nxt[`RCR_BIT_UNLOCK] = 1'b0;
                end else if (key_r == rcr_pkg::RCR_KEY_OPEN) begin
                    cfg_nxt[`RCR_BIT_UNLOCK] = 1'b1;
                end
                if (unlock) begin
                    cfg_nxt[`RCR_BIT_RUN] = dat_i[`RCR_BIT_RUN];
                end
            end
        end
        if (wr && idx == `RCR_ADR_ACFG && sel_i[1]) begin
            acfg_nxt[`RCR_PTR_HI:`RCR_PTR_LO] = dat_i[`RCR_PTR_HI:`RCR_PTR_LO];
        end
        if (wr && idx == `RCR_ADR_TVAL && unlock) begin
            tkw_nxt = 1'b1;
            if (sel_i[0] && tw.ptr_q == 2'h0) begin
                cfg_nxt[`RCR_BIT_STAT] = 1'b0;
            end
        end
        cfg_nxt[`RCR_PTR_HI:`RCR_PTR_LO]  = tw.ptr_nxt_view;
        acfg_nxt[`RCR_PTR_HI:`RCR_PTR_LO] = aw.ptr_nxt_view;
    end
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            cfg_r <= `RCR_CFG_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            acfg_r <= `RCR_CFG_RST;
        end else begin
            acfg_r <= acfg_nxt;
        end
    end
    always_ff @(posedge clk_i) begin
        if (wr && idx == `RCR_ADR_TVAL && unlock) begin
            if (sel_i[0]) begin
                tk_r[t_lo] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                tk_r[t_hi] <= dat_i[15:8];
            end
        end
        if (wr && idx == `RCR_ADR_AVAL && aw.ptr_q != 2'h3) begin
            if (sel_i[0]) begin
                al_r[a_lo] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                al_r[a_hi] <= dat_i[15:8];
            end
        end
    end
    // ************************************************************
    // read data and ack
    // ************************************************************
    always_comb begin
        ack_nxt = req;
        dat_nxt = 32'h0000_0000;
        if (rd) begin
            case (idx)
                `RCR_ADR_CFG:   dat_nxt[15:0] = cfg_r;
                `RCR_ADR_ACFG:  dat_nxt[15:0] = acfg_r;
                // pair chosen by the pointer before this read decrements it
                `RCR_ADR_TVAL:  dat_nxt[15:0] = {(tw.ptr_q == 2'h3) ? 8'h00 : tk_r[t_hi],
                                                 tk_r[t_lo]};
                `RCR_ADR_AVAL:  dat_nxt[15:0] = (aw.ptr_q == 2'h3) ? 16'h0000
                                               : {al_r[a_hi], al_r[a_lo]};
                `RCR_ADR_PULSE: dat_nxt[9:0]  = cal_pulses_o;
                default:        dat_nxt = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            ack_r    <= 1'b0;
            dat_r    <= 32'h0000_0000;
            tkw_r    <= 1'b0;
            key_r    <= rcr_pkg::RCR_KEY_IDLE;
            keyage_r <= 2'h0;
        end else begin
            ack_r    <= ack_nxt;
            dat_r    <= dat_nxt;
            tkw_r    <= tkw_nxt;
            key_r    <= key_nxt;
            keyage_r <= keyage_nxt;
        end
    end
    assign ack_o   = ack_r;
    assign dat_o   = dat_r;
    assign tk_wr_o = tkw_r;
    assign run_o   = cfg_r[`RCR_BIT_RUN];
    rcr_cal u_cal (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .minute_i (minute_i),
        .code_i   (cfg_r[`RCR_CAL_HI:0]),
        .add_o    (cal_add_o),
        .drop_o   (cal_drop_o),
        .pulses_o (cal_pulses_o)
    );
    // ************************************************************
    // checks
    // ************************************************************
    AST_LOCKED_WRITE: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (wr && idx == `RCR_ADR_TVAL && !unlock) |=> !tkw_r)
        else $error("timekeeping write accepted while locked");
    AST_RUN_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        !unlock |=> (run_o == $past(run_o)))
        else $error("run enable changed while locked");
    AST_UNLOCK_KEY: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (!unlock && key_r != rcr_pkg::RCR_KEY_OPEN) |=> !unlock)
        else $error("unlock set without key sequence");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");
    AST_STAT_CLR: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (wr && idx == `RCR_ADR_TVAL && unlock && sel_i[0] && tw.ptr_q == 2'h0)
        |=> !cfg_r[`RCR_BIT_STAT])
        else $error("status not cleared by minute/second write");
    // key steps as sequences; a foreign access in between spoils the key
    sequence key_first_s;
        key_wr && dat_i[7:0] == `RCR_KEY1 && key_r == rcr_pkg::RCR_KEY_IDLE;
    endsequence
    sequence key_second_s;
        key_wr && dat_i[7:0] == `RCR_KEY2 && key_r == rcr_pkg::RCR_KEY_GOT1;
    endsequence
    sequence unlock_set_s;
        wr && idx == `RCR_ADR_CFG && sel_i[1] && dat_i[`RCR_BIT_UNLOCK]
            && key_r == rcr_pkg::RCR_KEY_OPEN;
    endsequence
    AST_KEY_OPEN: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        key_first_s ##[1:3] key_second_s |=> key_r == rcr_pkg::RCR_KEY_OPEN)
        else $error("key sequence did not open the window");
    AST_KEY_SET: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        key_second_s ##[1:3] unlock_set_s |=> unlock)
        else $error("unlock not set inside the key window");
    AST_KEY_CLOSE: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (key_r == rcr_pkg::RCR_KEY_OPEN && req) |=> key_r == rcr_pkg::RCR_KEY_IDLE)
        else $error("key window stayed open after an access");
    AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        req |=> ack_r)
        else $error("request not acknowledged");
    // load beats any decrement in the same cycle
    AST_PTR_LOAD: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        tw.load |=> cfg_r[`RCR_PTR_HI:`RCR_PTR_LO] == $past(dat_i[`RCR_PTR_HI:`RCR_PTR_LO]))
        else $error("timer pointer load lost");
    AST_APTR_LOAD: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        aw.load |=> aw.ptr_q == $past(dat_i[`RCR_PTR_HI:`RCR_PTR_LO]))
        else $error("alarm pointer load lost");
    AST_YEAR_HIGH: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (rd && idx == `RCR_ADR_TVAL && tw.ptr_q == 2'h3) |=> dat_r[15:8] == 8'h00)
        else $error("unused high byte beside year not zero");
    AST_ALARM_NONE: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (rd && idx == `RCR_ADR_AVAL && aw.ptr_q == 2'h3) |=> dat_r[15:0] == 16'h0000)
        else $error("alarm window slot three not empty");
    AST_MINUTE_SECOND_PAIR_READ: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (rd && idx == `RCR_ADR_TVAL && tw.ptr_q == 2'h0)
        |=> dat_r[15:0] == {tk_r[1], tk_r[0]})
        else $error("minute/second pair not returned at pointer zero");
    AST_RUN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (wr && idx == `RCR_ADR_CFG && sel_i[1] && unlock)
        |=> run_o == $past(dat_i[`RCR_BIT_RUN]))
        else $error("run enable write lost while unlocked");
    AST_TK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (wr && idx == `RCR_ADR_TVAL && unlock) |=> tkw_r)
        else $error("unlocked timekeeping write not reported");
endmodule
`default_nettype wire

// file: verification/rcr_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rcr_core_tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic        clk_i;
    logic        rst_i;
    logic        por_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [5:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        minute_i;
    logic        run_o;
    logic        cal_add_o;
    logic        cal_drop_o;
    logic [9:0]  cal_pulses_o;
    logic        tk_wr_o;
    int          err_total;
    int          total_checks;
    int          cycles;
    int          tk_cnt;
    integer      seed;
    logic [15:0] tv [4];
    logic [15:0] av [3];
    logic [15:0] tmask [4];
    logic [31:0] q;
    logic [7:0]  codes [6];
    logic        seen_add;
    logic        seen_drop;
    logic [9:0]  seen_pls;

    rcr_core u_rcr_core (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .por_i        (por_i),
        .cyc_i        (cyc_i),
        .stb_i        (stb_i),
        .we_i         (we_i),
        .adr_i        (adr_i),
        .sel_i        (sel_i),
        .dat_i        (dat_i),
        .dat_o        (dat_o),
        .ack_o        (ack_o),
        .minute_i     (minute_i),
        .run_o        (run_o),
        .cal_add_o    (cal_add_o),
        .cal_drop_o   (cal_drop_o),
        .cal_pulses_o (cal_pulses_o),
        .tk_wr_o      (tk_wr_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ************************************************************
    // monitors and tasks
    // ************************************************************
    always @(posedge clk_i) begin
        cycles++;
        if (tk_wr_o === 1'b1) tk_cnt++;
        if (cal_add_o === 1'b1 || cal_drop_o === 1'b1) begin
            seen_add  = cal_add_o;
            seen_drop = cal_drop_o;
            seen_pls  = cal_pulses_o;
        end
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; waits on ack with no assumed latency
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] rd);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {a, 2'b00};
        sel_i <= s;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        chk("ack", 32'h1, {31'h0, ack_o});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd16(input logic [3:0] a, input logic [3:0] s, output logic [15:0] v);
        wb(1'b0, a, s, 32'h0, q);
        v = q[15:0];
    endtask

    task automatic cfg_is(input string what, input logic [15:0] exp);
        logic [15:0] v;
        rd16(4'h0, 4'h3, v);
        chk(what, {16'h0, exp}, {16'h0, v});
    endtask

    task automatic unlock(input logic [15:0] cfg);
        wb(1'b1, 4'h4, 4'h1, 32'h55, q);
        wb(1'b1, 4'h4, 4'h1, 32'haa, q);
        wb(1'b1, 4'h0, 4'h3, {16'h0, cfg}, q);
    endtask

    function automatic logic [11:0] cal_exp(input logic [7:0] c);
        logic [9:0] p;
        p = c[7] ? 10'((9'h100 - {1'b0, c}) * 4) : 10'({2'h0, c} * 4);
        return {(c != 8'h00) && !c[7], c[7], p};
    endfunction

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [15:0] v;
        seed = 68;
        err_total = 0;
        total_checks = 0;
        cycles = 0;
        tk_cnt = 0;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, minute_i} = '0;
        rst_i = 1'b1;
        por_i = 1'b1;
        tmask = '{16'hffff, 16'hffff, 16'hffff, 16'h00ff};
        codes = '{8'h01, 8'h7f, 8'hff, 8'h80, 8'h00, 8'h00};
        codes[5] = 8'($random(seed));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_i);
        cfg_is("cfg after por", 16'h0000);
        $display("test reset done");

        unlock(16'h2300);
        cfg_is("cfg unlocked ptr3", 16'h2300);
        for (int i = 3; i >= 0; i--) begin
            tv[i] = 16'($random(seed));
            wb(1'b1, 4'h1, 4'h3, {16'h0, tv[i]}, q);
        end
        cfg_is("timer ptr floor", 16'h2000);
        tv[0] = 16'($random(seed));
        wb(1'b1, 4'h1, 4'h3, {16'h0, tv[0]}, q);
        cfg_is("timer ptr stays", 16'h2000);
        chk("tk writes", 32'd5, tk_cnt);
        wb(1'b1, 4'h0, 4'h3, 32'h0300, q);
        for (int i = 3; i >= 0; i--) begin
            rd16(4'h1, (i == 2) ? 4'h2 : 4'h3, v);
            chk("timer window", {16'h0, tv[i] & tmask[i]}, {16'h0, v & tmask[i]});
        end
        rd16(4'h1, 4'h1, v);
        chk("timer window at 00", {16'h0, tv[0]}, {16'h0, v});
        cfg_is("timer ptr after reads", 16'h0000);
        wb(1'b1, 4'h1, 4'h3, {16'h0, ~tv[0]}, q);
        rd16(4'h1, 4'h3, v);
        chk("locked timer write", {16'h0, tv[0]}, {16'h0, v});
        chk("tk writes locked", 32'd5, tk_cnt);
        $display("test timer window done");

        // an access between the key and the set spoils the sequence
        wb(1'b1, 4'h4, 4'h1, 32'h55, q);
        wb(1'b1, 4'h4, 4'h1, 32'haa, q);
        wb(1'b0, 4'h5, 4'h3, 32'h0, q);
        wb(1'b1, 4'h0, 4'h3, 32'h2000, q);
        cfg_is("late unlock", 16'h0000);
        wb(1'b1, 4'h0, 4'h3, 32'h9000, q);
        chk("run locked", 32'h0, {31'h0, run_o});
        cfg_is("run and status locked", 16'h0000);
        // run needs the unlock bit already set when it is written
        unlock(16'h2000);
        wb(1'b1, 4'h0, 4'h3, 32'ha000, q);
        chk("run unlocked", 32'h1, {31'h0, run_o});
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cfg_is("cfg kept over reset", 16'ha000);
        por_i <= 1'b1;
        @(posedge clk_i);
        por_i <= 1'b0;
        @(posedge clk_i);
        cfg_is("cfg cleared by por", 16'h0000);
        $display("test lock and reset done");

        wb(1'b1, 4'h2, 4'h3, 32'h0200, q);
        for (int i = 2; i >= 0; i--) begin
            av[i] = 16'($random(seed));
            wb(1'b1, 4'h3, 4'h3, {16'h0, av[i]}, q);
        end
        rd16(4'h2, 4'h3, v);
        chk("alarm ptr floor", 32'h0, {30'h0, v[9:8]});
        wb(1'b1, 4'h2, 4'h3, 32'h0300, q);
        rd16(4'h3, 4'h3, v);
        chk("alarm window 11", 32'h0, {16'h0, v});
        for (int i = 2; i >= 0; i--) begin
            rd16(4'h3, (i == 1) ? 4'h1 : 4'h3, v);
            chk("alarm window", {16'h0, av[i]}, {16'h0, v});
        end
        rd16(4'h2, 4'h3, v);
        chk("alarm ptr after reads", 32'h0, {30'h0, v[9:8]});
        $display("test alarm window done");

        for (int i = 0; i < 6; i++) begin
            wb(1'b1, 4'h0, 4'h3, {24'h0, codes[i]}, q);
            seen_add = 1'b0;
            seen_drop = 1'b0;
            seen_pls = 10'h0;
            minute_i <= 1'b1;
            @(posedge clk_i);
            minute_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            chk("trim", {20'h0, cal_exp(codes[i])}, {20'h0, seen_add, seen_drop, seen_pls});
        end
        $display("test trim done");

        rd16(4'hf, 4'h3, v);
        chk("unmapped read", 32'h0, {16'h0, v});
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
